/* verilog/cdr_pkg.sv */
// Purpose: constants and carrier types for the cpu dedicated register set
// Assumes: 8-bit core datapath drives update strobes each cycle
// Notes: see behaviour list below
// Behaviour
// - instruction pointer is 16 bits, loads FFFD on reset
// - 16-bit accumulator; 8-bit ops use its lower byte; undefined at reset
// - 16-bit temporary accumulator is second operand; 8-bit ops use low byte
// - offset base, aux and stack pointers: 16 bits, undefined at reset
// - 16-bit flag word: upper byte bank select, lower byte condition codes
// - reset clears interrupt enable, sets both level bits; rest undefined
// - half carry set on carry or borrow from bit 3 into bit 4
// - interrupts accepted only while enable flag is one; cleared on reset
// - service only requests of higher priority than current two-bit level
// - negative flag follows result most significant bit
// - zero flag set when result is zero, cleared otherwise
// - overflow flag set on two's-complement overflow, cleared otherwise
// - carry flag from bit 7 carry or borrow; shifts load shifted-out bit
// - 8-bit general registers in memory, eight per bank, up to 32 banks
// - 64 KB space: io lowest, data above, code and vectors at top
`default_nettype none
package cdr_pkg;
	localparam logic [15:0] CDR_IP_RESET = 16'hFFFD;
	// undefined in hardware; zero keeps runs repeatable
	localparam logic [15:0] CDR_WORD_RESET = 16'h0000;
	// condition-code bit positions
	localparam int CDR_CC_H = 7;
	localparam int CDR_CC_I = 6;
	localparam int CDR_CC_IL1 = 5;
	localparam int CDR_CC_IL0 = 4;
	localparam int CDR_CC_N = 3;
	localparam int CDR_CC_Z = 2;
	localparam int CDR_CC_V = 1;
	localparam int CDR_CC_C = 0;
	localparam logic [7:0] CDR_CC_RESET = 8'h30;
	localparam logic [4:0] CDR_BANK_RESET = 5'h00;
	localparam logic [15:0] CDR_BANK_BASE = 16'h0100; // default mapping base
	localparam int CDR_REGS_PER_BANK = 8;
	localparam int CDR_BANKS = 32;

	// register selector for writes
	typedef enum logic [6:0] {
		CDR_SEL_IP = 7'h01,
		CDR_SEL_ACC = 7'h02,
		CDR_SEL_TMP = 7'h04,
		CDR_SEL_IDX = 7'h08,
		CDR_SEL_AUX = 7'h10,
		CDR_SEL_SP = 7'h20,
		CDR_SEL_FW = 7'h40
	} cdr_sel_t;

	// alu result with operands for flag evaluation
	typedef struct packed {
		logic valid;
		logic wide;     // 16-bit operation
		logic sub;      // subtract / borrow sense
		logic shift;    // shift instruction
		logic shift_out;
		logic [15:0] op_a;
		logic [15:0] op_b;
		logic [15:0] result;
	} cdr_alu_t;

	typedef struct packed {
		logic en;
		cdr_sel_t sel;
		logic [15:0] data;
	} cdr_wr_t;
endpackage
`default_nettype wire

/* verilog/cdr_bank_ram.sv */
// Purpose: banked general register storage, 32 banks of eight bytes
// Assumes: single port, registered read data
// Notes: contents undefined after reset
`timescale 1ns/100ps
`default_nettype none
module cdr_bank_ram (
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem_q [0:255];

	// storage and registered read
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem_q[addr_i] <= wdata_i;
		end
		rdata_o <= mem_q[addr_i];
	end
endmodule
`default_nettype wire

/* verilog/cdr_core_regs.sv */
// Purpose: dedicated cpu registers, flag word and interrupt level gating
// Assumes: datapath presents one write and one alu result per cycle
// Notes: registers left undefined by the hardware reset to zero here
`timescale 1ns/100ps
`default_nettype none
module cdr_core_regs
	import cdr_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire cdr_pkg::cdr_wr_t wr_i,
	input wire cdr_pkg::cdr_alu_t alu_i,
	input wire logic ip_inc_i,
	input wire logic irq_req_i,
	input wire logic [1:0] irq_level_i,
	input wire logic gpr_we_i,
	input wire logic [2:0] gpr_idx_i,
	input wire logic [7:0] gpr_wdata_i,
	input wire logic [15:0] bank_base_i,
	output logic [15:0] instr_pointer_o,
	output logic [15:0] acc_o,
	output logic [15:0] tmp_acc_o,
	output logic [15:0] offset_base_reg_o,
	output logic [15:0] aux_mem_pointer_o,
	output logic [15:0] push_pop_pointer_o,
	output logic [15:0] cpu_flag_word_o,
	output logic irq_take_o,
	output logic [15:0] gpr_addr_o,
	output logic [7:0] gpr_rdata_o
);
	import cdr_pkg::*;

	// reset release chain
	logic rst_s1_q;
	logic rst_b_q;
	// dedicated registers, current and next
	logic [15:0] ip_q, ip_d;
	logic [15:0] acc_q, acc_d;
	logic [15:0] tmp_q, tmp_d;
	logic [15:0] idx_q, idx_d;
	logic [15:0] aux_q, aux_d;
	logic [15:0] sp_q, sp_d;
	// flag word halves
	logic [4:0] bank_q, bank_d;
	logic [7:0] cc_q, cc_d;
	// interrupt decision and banked register address
	logic take_q, take_d;
	logic [15:0] gaddr_q, gaddr_d;
	logic [7:0] ram_addr;

	// numeric priority: 0 highest; code 01 ranks with 00
	function automatic logic [1:0] lvl_rank(input logic [1:0] code);
		lvl_rank = (code == 2'b01) ? 2'b00 : code;
	endfunction

	// flag evaluation from an alu result, 8 or 16 bit
	function automatic logic [7:0] flags(input cdr_alu_t a,
		input logic [7:0] cc);
		logic msb_a, msb_b, msb_r;
		logic [16:0] sum;
		logic [4:0] nib;
		flags = cc;
		msb_a = a.wide ? a.op_a[15] : a.op_a[7];
		msb_b = a.wide ? a.op_b[15] : a.op_b[7];
		msb_r = a.wide ? a.result[15] : a.result[7];
		nib = a.sub ? ({1'b0, a.op_a[3:0]} - {1'b0, a.op_b[3:0]})
			: ({1'b0, a.op_a[3:0]} + {1'b0, a.op_b[3:0]});
		sum = a.sub ? ({9'h000, a.op_a[7:0]} - {9'h000, a.op_b[7:0]})
			: ({9'h000, a.op_a[7:0]} + {9'h000, a.op_b[7:0]});
		flags[CDR_CC_H] = nib[4];
		flags[CDR_CC_N] = msb_r;
		flags[CDR_CC_Z] = a.wide ? (a.result == 16'h0000)
			: (a.result[7:0] == 8'h00);
		// overflow: operand signs agree (after sub inversion), result differs
		flags[CDR_CC_V] = (msb_a ~^ (msb_b ^ a.sub))
			&& (msb_r != msb_a);
		flags[CDR_CC_C] = a.shift ? a.shift_out : sum[8];
	endfunction

	// reset release through two flops
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_s1_q <= 1'b0;
			rst_b_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_b_q <= rst_s1_q;
		end
	end

	// instruction pointer: a write beats the increment
	always_comb begin
		ip_d = ip_q;
		if (wr_i.en && wr_i.sel == CDR_SEL_IP) begin
			ip_d = wr_i.data;
		end else if (ip_inc_i) begin
			ip_d = ip_q + 16'h0001;
		end
	end

	// program fetch starts from the top of the space after reset
	always_ff @(posedge sys_clk_i or negedge rst_b_q) begin
		if (!rst_b_q) begin
			ip_q <= CDR_IP_RESET;
		end else begin
			ip_q <= ip_d;
		end
	end

	// working registers: an explicit write beats an alu result
	always_comb begin
		acc_d = acc_q;
		tmp_d = tmp_q;
		idx_d = idx_q;
		aux_d = aux_q;
		sp_d = sp_q;
		// 8-bit results leave the upper accumulator byte alone
		if (alu_i.valid) begin
			if (alu_i.wide) begin
				acc_d = alu_i.result;
			end else begin
				acc_d = {acc_q[15:8], alu_i.result[7:0]};
			end
		end
		if (wr_i.en) begin
			case (wr_i.sel)
				CDR_SEL_ACC: acc_d = wr_i.data;
				CDR_SEL_TMP: tmp_d = wr_i.data;
				CDR_SEL_IDX: idx_d = wr_i.data;
				CDR_SEL_AUX: aux_d = wr_i.data;
				CDR_SEL_SP: sp_d = wr_i.data;
				default: ;
			endcase
		end
	end

	// undefined in hardware; cleared here so runs repeat exactly
	always_ff @(posedge sys_clk_i or negedge rst_b_q) begin
		if (!rst_b_q) begin
			acc_q <= CDR_WORD_RESET;
			tmp_q <= CDR_WORD_RESET;
			idx_q <= CDR_WORD_RESET;
			aux_q <= CDR_WORD_RESET;
			sp_q <= CDR_WORD_RESET;
		end else begin
			acc_q <= acc_d;
			tmp_q <= tmp_d;
			idx_q <= idx_d;
			aux_q <= aux_d;
			sp_q <= sp_d;
		end
	end

	// flag word: a whole-word write beats the alu flag update
	always_comb begin
		bank_d = bank_q;
		cc_d = cc_q;
		if (alu_i.valid) begin
			cc_d = flags(alu_i, cc_q);
		end
		// only five bank bits exist, the upper three read as zero
		if (wr_i.en && wr_i.sel == CDR_SEL_FW) begin
			bank_d = wr_i.data[12:8];
			cc_d = wr_i.data[7:0];
		end
	end

	// reset clears enable and sets both level bits; the other flag bits and the bank load zero
	always_ff @(posedge sys_clk_i or negedge rst_b_q) begin
		if (!rst_b_q) begin
			bank_q <= CDR_BANK_RESET;
			cc_q <= CDR_CC_RESET;
		end else begin
			bank_q <= bank_d;
			cc_q <= cc_d;
		end
	end

	// interrupt gating: enable flag and level comparison
	always_comb begin
		take_d = irq_req_i && cc_q[CDR_CC_I]
			&& (lvl_rank(irq_level_i)
			< lvl_rank({cc_q[CDR_CC_IL1], cc_q[CDR_CC_IL0]}));
	end

	// registered so the datapath sees one clean decision per cycle
	always_ff @(posedge sys_clk_i or negedge rst_b_q) begin
		if (!rst_b_q) begin
			take_q <= 1'h0;
		end else begin
			take_q <= take_d;
		end
	end

	// banked register address: integrator base plus bank and index
	always_comb begin
		gaddr_d = bank_base_i + {8'h00, bank_q, gpr_idx_i};
	end
	// ram index: 5-bit bank, 3-bit register
	assign ram_addr = {bank_q, gpr_idx_i};

	// address wraps inside the 64 KB space; no carry out is kept
	always_ff @(posedge sys_clk_i or negedge rst_b_q) begin
		if (!rst_b_q) begin
			gaddr_q <= CDR_WORD_RESET;
		end else begin
			gaddr_q <= gaddr_d;
		end
	end

	// outputs straight from flops
	assign instr_pointer_o = ip_q;
	assign acc_o = acc_q;
	assign tmp_acc_o = tmp_q;
	assign offset_base_reg_o = idx_q;
	assign aux_mem_pointer_o = aux_q;
	assign push_pop_pointer_o = sp_q;
	assign cpu_flag_word_o = {3'b000, bank_q, cc_q};
	assign irq_take_o = take_q;
	assign gpr_addr_o = gaddr_q;

	cdr_bank_ram u_ram (
		.clk_i(sys_clk_i),
		.we_i(gpr_we_i),
		.addr_i(ram_addr),
		.wdata_i(gpr_wdata_i),
		.rdata_o(gpr_rdata_o)
	);
endmodule
`default_nettype wire

/* test/cdr_core_regs_asserts.sv */
// Purpose: port checks for cdr_core_regs
// Assumes: inputs idle until reset is released
// Notes: flag checks only on plain alu cycles
`timescale 1ns/100ps
`default_nettype none
module cdr_core_regs_asserts
	import cdr_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire cdr_pkg::cdr_wr_t wr_i,
	input wire cdr_pkg::cdr_alu_t alu_i,
	input wire logic irq_req_i,
	input wire logic [1:0] irq_level_i,
	input wire logic [15:0] instr_pointer_o,
	input wire logic [15:0] acc_o,
	input wire logic [15:0] cpu_flag_word_o,
	input wire logic irq_take_o
);
	import cdr_pkg::*;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	logic n_x, z_x, t_x;
	logic [1:0] rq, rc;
	// expected flags; code 01 ranks with 00
	always_comb begin
		rq = irq_level_i == 2'h1 ? 2'h0 : irq_level_i;
		rc = cpu_flag_word_o[5:4] == 2'h1 ? 2'h0 : cpu_flag_word_o[5:4];
		t_x = irq_req_i & cpu_flag_word_o[CDR_CC_I] & (rq < rc);
		n_x = alu_i.wide ? alu_i.result[15] : alu_i.result[7];
		z_x = alu_i.wide ? ~|alu_i.result : ~|alu_i.result[7:0];
	end
	sequence s_alu;
		alu_i.valid && !wr_i.en;
	endsequence
	property p_ip_rst;
		$rose(rst_b_i) |-> instr_pointer_o == CDR_IP_RESET;
	endproperty
	a_ip_rst: assert property (p_ip_rst) else $error("ip reset");
	property p_cc_rst;
		$rose(rst_b_i) |-> cpu_flag_word_o[6:4] == 3'h3;
	endproperty
	a_cc_rst: assert property (p_cc_rst) else $error("cc reset");
	property p_acc_wr;
		wr_i.en && wr_i.sel == CDR_SEL_ACC |=> acc_o == $past(wr_i.data);
	endproperty
	a_acc_wr: assert property (p_acc_wr) else $error("acc write");
	property p_ip_wr;
		wr_i.en && wr_i.sel == CDR_SEL_IP |=> instr_pointer_o == $past(wr_i.data);
	endproperty
	a_ip_wr: assert property (p_ip_wr) else $error("ip write");
	property p_neg;
		s_alu |=> cpu_flag_word_o[CDR_CC_N] == $past(n_x);
	endproperty
	a_neg: assert property (p_neg) else $error("negative");
	property p_zero;
		s_alu |=> cpu_flag_word_o[CDR_CC_Z] == $past(z_x);
	endproperty
	a_zero: assert property (p_zero) else $error("zero");
	property p_shc;
		s_alu ##0 alu_i.shift
			|=> cpu_flag_word_o[CDR_CC_C] == $past(alu_i.shift_out);
	endproperty
	a_shc: assert property (p_shc) else $error("shift carry");
	property p_take;
		irq_req_i |=> irq_take_o == $past(t_x);
	endproperty
	a_take: assert property (p_take) else $error("irq accept");
endmodule
bind cdr_core_regs cdr_core_regs_asserts u_chk (.*);
`default_nettype wire

/* test/cdr_dp_model.sv */
// Purpose: datapath stand-in forming each alu result
// Assumes: op is {valid, wide, sub, shift}
// Notes: left shift only; shifted-out bit follows width
`timescale 1ns/100ps
`default_nettype none
module cdr_dp_model
	import cdr_pkg::*;
(
	input wire logic [15:0] a_i,
	input wire logic [15:0] b_i,
	input wire logic [3:0] op_i,
	output cdr_pkg::cdr_alu_t alu_o
);
	import cdr_pkg::*;
	logic [15:0] r;
	// operands travel with the result so flags can be judged
	assign r = op_i[0] ? a_i << 1 : op_i[1] ? a_i - b_i : a_i + b_i;
	assign alu_o = '{op_i[3], op_i[2], op_i[1], op_i[0],
		op_i[2] ? a_i[15] : a_i[7], a_i, b_i, r};
endmodule
`default_nettype wire

/* test/cdr_core_regs_test.sv */
// Purpose: self-checking bench for cdr_core_regs
// Assumes: undefined reset values read as anything
// Notes: shift cycles skip half carry and overflow
`timescale 1ns/100ps
`default_nettype none
module cdr_core_regs_test;
	import cdr_pkg::*;
	logic sys_clk_i = 1'h0, rst_b_i = 1'h0, ip_inc_i = 1'h0, irq_req_i = 1'h0;
	logic gpr_we_i = 1'h0, irq_take_o, sub, wide, shl;
	logic [1:0] irq_level_i = 2'h0;
	logic [2:0] gpr_idx_i = 3'h0;
	logic [3:0] op = 4'h0;
	logic [4:0] m, x;
	logic [7:0] gpr_wdata_i = 8'h0, rd;
	logic [15:0] a = '0, b = '0, bank_base_i = '0, res, ma, fw, ga, o [6], d [6];
	cdr_wr_t wr_i = '0;
	cdr_alu_t alu_i;
	int n_errors = 0, n_compared = 0, cyc = 0, seed = 32'hA526, w;
	cdr_dp_model DP (.a_i(a), .b_i(b), .op_i(op), .alu_o(alu_i));
	cdr_core_regs DUT (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .wr_i(wr_i),
		.alu_i(alu_i), .ip_inc_i(ip_inc_i), .irq_req_i(irq_req_i),
		.irq_level_i(irq_level_i), .gpr_we_i(gpr_we_i), .gpr_idx_i(gpr_idx_i),
		.gpr_wdata_i(gpr_wdata_i), .bank_base_i(bank_base_i),
		.instr_pointer_o(o[0]), .acc_o(o[1]), .tmp_acc_o(o[2]),
		.offset_base_reg_o(o[3]), .aux_mem_pointer_o(o[4]),
		.push_pop_pointer_o(o[5]), .cpu_flag_word_o(fw), .irq_take_o(irq_take_o),
		.gpr_addr_o(ga), .gpr_rdata_o(rd));
	assign {shl, sub, wide} = {op[0], op[1], op[2]};
	function automatic logic [1:0] rk(input logic [1:0] l);
		return l == 2'h1 ? 2'h0 : l;
	endfunction
	task chk(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %0t got %h want %h", $time, g, e);
		end
	endtask
	task end_of_test;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// clock, and a hang limit well above the ~150 cycles needed
	always #12.5 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc > 2000) begin
			n_errors++;
			end_of_test;
		end
	end
	initial begin
		repeat (12) @(negedge sys_clk_i);
		rst_b_i = 1'h1;
		repeat (4) @(negedge sys_clk_i);
		chk(o[0], CDR_IP_RESET);
		chk(16'(fw[6:4]), 16'h0003);
		for (int i = 0; i < 6; i++) begin
			d[i] = 16'($random(seed));
			wr_i = '{1'h1, cdr_sel_t'(7'h01 << i), d[i]};
			@(negedge sys_clk_i);
			chk(o[i], d[i]);
		end
		wr_i.en = 1'h0;
		ip_inc_i = 1'h1;
		repeat (3) @(negedge sys_clk_i);
		ip_inc_i = 1'h0;
		chk(o[0], d[0] + 16'h0003);
		// back-to-back random alu cycles against the integer model
		ma = d[1];
		for (int i = 0; i < 60; i++) begin
			a = 16'($random(seed));
			b = 16'($random(seed));
			op = {1'h1, 3'($random(seed))};
			@(negedge sys_clk_i);
			w = wide ? 15 : 7;
			res = shl ? a << 1 : sub ? a - b : a + b;
			ma = wide ? res : {ma[15:8], res[7:0]};
			x[4] = sub ? a[3:0] < b[3:0] : a[3:0] + b[3:0] > 5'h0F;
			x[3] = res[w];
			x[2] = wide ? res == 16'h0 : res[7:0] == 8'h0;
			x[1] = a[w] ^ res[w] && (a[w] ^ b[w]) == sub;
			x[0] = shl ? a[w] : sub ? a[7:0] < b[7:0] : a[7:0] + b[7:0] > 9'h0FF;
			m = shl ? 5'h0D : 5'h1F;
			x = x & m;
			chk(o[1], ma);
			chk(16'({fw[7], fw[3:0]} & m), 16'(x));
		end
		op = 4'h0;
		for (int i = 0; i < 32; i++) begin
			irq_req_i = 1'h0;
			wr_i = '{1'h1, CDR_SEL_FW,
				{3'h0, 5'($random(seed)), 1'h0, 3'(i >> 2), 4'h0}};
			@(negedge sys_clk_i);
			// byte written two edges ago reads back from the bank store
			if (gpr_we_i) chk(16'(rd), 16'(gpr_wdata_i));
			wr_i.en = 1'h0;
			irq_req_i = 1'h1;
			irq_level_i = 2'(i);
			{bank_base_i, gpr_idx_i, gpr_we_i, gpr_wdata_i} = 28'($random(seed));
			@(negedge sys_clk_i);
			w = i[4] && rk(2'(i)) < rk(2'(i >> 2));
			chk(16'(irq_take_o), 16'(w));
			chk(ga, bank_base_i + {wr_i.data[12:8], gpr_idx_i});
			chk(fw, {3'h0, wr_i.data[12:0]});
		end
		end_of_test;
	end
endmodule
`default_nettype wire
